// ===== hdl/osr_matrix.sv
// Purpose: Routes internal protection events to power outputs, signal outputs and LEDs.
// Assumes: Source events are synchronous to CLOCK_IN; extension-present is an async pin.
// Notes: Every output is the registered OR of its selected sources plus any fixed routing.
//
// Behaviour
// - Power outputs driven by words one to three
// - Signal outputs driven by words four to eight
// - Output is OR of selected sources
// - Checksum equals sum of set switch weights
// - Third power output always carries trip lockout
// - Second power output always carries breaker-failure trip
// - Second signal output always carries fault warning
// - Switches one to twelve: stage start/trip pairs
// - Switches 13-15: thermal alarm, trip, external trip
// - Switches 16-21: auto-reclose signals in order
// - Switch 22 arc trip, 23 light output
// - Reset defaults: trips, starts, then zero
// - Absent extension reads 9999 for last three
// - Each LED driven by its own word
// - Indicator switches 1-14 source order
// - Indicator switches 15-23 order, default zero
module osr_matrix
  import osr_pkg::*;
(
  input wire logic CLOCK_IN, // System clock, 50 MHz
  input wire logic RESET_IN, // Synchronous reset, active high
  input wire osr_sources_t SOURCES_IN, // Internal event signals
  input wire logic IO_EXT_PRESENT_IN, // Optional I/O extension fitted, pin
  input wire logic CFG_WR_IN, // Write selection word, one-cycle strobe
  input wire logic CFG_RD_IN, // Read selection word, one-cycle strobe
  input wire logic [OSR_INDEX_W-1:0] CFG_INDEX_IN, // Word index 0..15
  input wire logic [OSR_SWITCHES-1:0] CFG_WDATA_IN, // Word value to write
  output logic [OSR_SWITCHES-1:0] CFG_RDATA_OUT, // Read word, equals checksum
  output logic CFG_RVALID_OUT, // Read data valid, one-cycle pulse
  output logic [OSR_NUM_POWER-1:0] POWER_OUT, // Power output contacts
  output logic [OSR_NUM_SIGNAL-1:0] SIGNAL_OUT, // Signal output contacts
  output logic [OSR_NUM_LEDS-1:0] LED_OUT // Indicator LEDs
);

  osr_word_t select_reg [OSR_NUM_WORDS];
  logic io_ext_meta_reg;
  logic io_ext_sync_reg;
  osr_word_t out_src;
  osr_word_t led_src;
  logic [OSR_NUM_OUT_WORDS-1:0] out_hit;
  logic [OSR_NUM_LEDS-1:0] led_hit;
  logic [OSR_NUM_POWER-1:0] power_next;
  logic [OSR_NUM_SIGNAL-1:0] signal_next;

  // Extension pin is asynchronous to the matrix clock
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      io_ext_meta_reg <= 1'b0;
      io_ext_sync_reg <= 1'b0;
    end
    else
    begin
      io_ext_meta_reg <= IO_EXT_PRESENT_IN;
      io_ext_sync_reg <= io_ext_meta_reg;
    end
  end

  // Word value is its own checksum since switch n weighs 2**(n-1)
  function automatic osr_word_t reset_value(input int idx);
    if (idx < OSR_NUM_POWER)
      reset_value = OSR_RST_POWER;
    else if (idx < int'(OSR_IDX_SIGNAL3))
      reset_value = OSR_RST_SIGNAL_START;
    else
      reset_value = OSR_RST_ZERO;
  endfunction

  genvar gw;
  generate
    for (gw = 0; gw < OSR_NUM_WORDS; gw++)
    begin : g_word
      always_ff @(posedge CLOCK_IN)
      begin
        if (RESET_IN)
          select_reg[gw] <= reset_value(gw);
        else if (CFG_WR_IN && (CFG_INDEX_IN == OSR_INDEX_W'(gw)))
          select_reg[gw] <= CFG_WDATA_IN;
      end
    end
  endgenerate

  // Readback; extension words still store writes so settings survive fitting later
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      CFG_RDATA_OUT <= OSR_RST_ZERO;
      CFG_RVALID_OUT <= 1'b0;
    end
    else
    begin
      CFG_RVALID_OUT <= CFG_RD_IN;
      if (CFG_RD_IN)
      begin
        if (!io_ext_sync_reg && (CFG_INDEX_IN >= OSR_IDX_SIGNAL3) && (CFG_INDEX_IN <= OSR_IDX_SIGNAL5))
          CFG_RDATA_OUT <= OSR_ABSENT_VALUE;
        else
          CFG_RDATA_OUT <= select_reg[CFG_INDEX_IN];
      end
    end
  end

  // Output matrix source vector, switch n at bit n-1
  genvar gs;
  generate
    for (gs = 0; gs < OSR_NUM_STAGES; gs++)
    begin : g_stage
      assign out_src[2*gs] = SOURCES_IN.stage_start[gs];
      assign out_src[2*gs+1] = SOURCES_IN.stage_trip[gs];
      assign led_src[gs] = SOURCES_IN.stage_trip[gs];
    end
  endgenerate

  assign out_src[12] = SOURCES_IN.thermal_alarm;
  assign out_src[13] = SOURCES_IN.thermal_trip;
  assign out_src[14] = SOURCES_IN.external_trip;
  assign out_src[15] = SOURCES_IN.auto_reclose_open_cmd;
  assign out_src[16] = SOURCES_IN.auto_reclose_close_cmd;
  assign out_src[17] = SOURCES_IN.auto_reclose_definite_trip;
  assign out_src[18] = SOURCES_IN.auto_reclose_failed;
  assign out_src[19] = SOURCES_IN.auto_reclose_shot_due;
  assign out_src[20] = SOURCES_IN.auto_reclose_lockout;
  assign out_src[21] = SOURCES_IN.arc_trip;
  assign out_src[22] = SOURCES_IN.light_output;

  assign led_src[6] = SOURCES_IN.thermal_alarm;
  assign led_src[7] = SOURCES_IN.thermal_trip;
  assign led_src[8] = SOURCES_IN.trip_lockout;
  assign led_src[9] = SOURCES_IN.auto_reclose_definite_trip;
  assign led_src[10] = SOURCES_IN.auto_reclose_shot_due;
  assign led_src[11] = SOURCES_IN.auto_reclose_lockout;
  assign led_src[12] = SOURCES_IN.circuit_breaker_open;
  assign led_src[13] = SOURCES_IN.circuit_breaker_closed;
  assign led_src[18:14] = SOURCES_IN.digital_inputs;
  assign led_src[19] = SOURCES_IN.arc_trip;
  assign led_src[20] = SOURCES_IN.light_output;
  assign led_src[21] = SOURCES_IN.breaker_failure_trip;
  assign led_src[22] = SOURCES_IN.recorder_triggered;

  genvar go;
  generate
    for (go = 0; go < OSR_NUM_OUT_WORDS; go++)
    begin : g_out
      assign out_hit[go] = |(out_src & select_reg[go]);
    end
    for (go = 0; go < OSR_NUM_LEDS; go++)
    begin : g_led
      assign led_hit[go] = |(led_src & select_reg[go+OSR_NUM_OUT_WORDS]);
    end
  endgenerate

  // Fixed routings are ORed in and cannot be deselected
  always_comb
  begin
    power_next = out_hit[OSR_NUM_POWER-1:0];
    power_next[OSR_POWER_TWO_POS] = out_hit[OSR_POWER_TWO_POS] | SOURCES_IN.breaker_failure_trip;
    power_next[OSR_POWER_THREE_POS] = out_hit[OSR_POWER_THREE_POS] | SOURCES_IN.trip_lockout;
    signal_next = out_hit[OSR_NUM_OUT_WORDS-1:OSR_NUM_POWER];
    signal_next[OSR_SIGNAL_TWO_POS] = out_hit[OSR_NUM_POWER+OSR_SIGNAL_TWO_POS] | SOURCES_IN.external_fault_warning;
  end

  // One register stage, no latching of events
  always_ff @(posedge CLOCK_IN)
  begin
    if (RESET_IN)
    begin
      POWER_OUT <= '0;
      SIGNAL_OUT <= '0;
      LED_OUT <= '0;
    end
    else
    begin
      POWER_OUT <= power_next;
      SIGNAL_OUT <= signal_next;
      LED_OUT <= led_hit;
    end
  end

endmodule

// ===== hdl/osr_pkg.sv
// Purpose: Constants and types for the output signal routing matrix.
// Assumes: One selection word per output or indicator, 23 switches each.
// Notes: A word's checksum is its binary value.
package osr_pkg;

  localparam int OSR_SWITCHES = 23;
  localparam int OSR_NUM_POWER = 3;
  localparam int OSR_NUM_SIGNAL = 5;
  localparam int OSR_NUM_OUT_WORDS = 8;
  localparam int OSR_NUM_LEDS = 8;
  localparam int OSR_NUM_WORDS = 16;
  localparam int OSR_INDEX_W = 4;
  localparam int OSR_NUM_STAGES = 6;
  localparam int OSR_NUM_DI = 5;

  // Word indices on the configuration port
  localparam logic [3:0] OSR_IDX_POWER1 = 4'h0;
  localparam logic [3:0] OSR_IDX_POWER2 = 4'h1;
  localparam logic [3:0] OSR_IDX_POWER3 = 4'h2;
  localparam logic [3:0] OSR_IDX_SIGNAL1 = 4'h3;
  localparam logic [3:0] OSR_IDX_SIGNAL2 = 4'h4;
  localparam logic [3:0] OSR_IDX_SIGNAL3 = 4'h5;
  localparam logic [3:0] OSR_IDX_SIGNAL5 = 4'h7;
  localparam logic [3:0] OSR_IDX_IND1 = 4'h8;

  // Fixed routings, as positions within the output vectors
  localparam int OSR_POWER_TWO_POS = 1;
  localparam int OSR_POWER_THREE_POS = 2;
  localparam int OSR_SIGNAL_TWO_POS = 1;

  // Reset values (checksums 2108074, 5461 and 0)
  localparam logic [22:0] OSR_RST_POWER = 23'h202aaa;
  localparam logic [22:0] OSR_RST_SIGNAL_START = 23'h001555;
  localparam logic [22:0] OSR_RST_ZERO = 23'h000000;

  // Read answer for extension words when the I/O extension is missing
  localparam logic [22:0] OSR_ABSENT_VALUE = 23'd9999;

  typedef logic [OSR_SWITCHES-1:0] osr_word_t;

  // Internal event sources; stage order: phase low, phase high, phase instant,
  // earth fault low, earth fault high, phase discontinuity
  typedef struct packed {
    logic [OSR_NUM_STAGES-1:0] stage_start;
    logic [OSR_NUM_STAGES-1:0] stage_trip;
    logic thermal_alarm;
    logic thermal_trip;
    logic external_trip;
    logic auto_reclose_open_cmd;
    logic auto_reclose_close_cmd;
    logic auto_reclose_definite_trip;
    logic auto_reclose_failed;
    logic auto_reclose_shot_due;
    logic auto_reclose_lockout;
    logic arc_trip;
    logic light_output;
    logic trip_lockout;
    logic breaker_failure_trip;
    logic external_fault_warning;
    logic circuit_breaker_open;
    logic circuit_breaker_closed;
    logic [OSR_NUM_DI-1:0] digital_inputs;
    logic recorder_triggered;
  } osr_sources_t;

endpackage

// ===== verif/osr_matrix_sva.sv
// Purpose: Port-level checks for the routing matrix.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the matrix from the bench top file.
module osr_matrix_sva
  import osr_pkg::*;
(
  input wire logic CLOCK_IN, // Clock
  input wire logic RESET_IN, // Reset
  input wire osr_sources_t SOURCES_IN, // Events
  input wire logic IO_EXT_PRESENT_IN, // Extension pin
  input wire logic CFG_WR_IN, // Write strobe
  input wire logic CFG_RD_IN, // Read strobe
  input wire logic [OSR_INDEX_W-1:0] CFG_INDEX_IN, // Index
  input wire logic [OSR_SWITCHES-1:0] CFG_WDATA_IN, // Write data
  input wire logic [OSR_SWITCHES-1:0] CFG_RDATA_OUT, // Read data
  input wire logic CFG_RVALID_OUT, // Read valid
  input wire logic [OSR_NUM_POWER-1:0] POWER_OUT, // Power
  input wire logic [OSR_NUM_SIGNAL-1:0] SIGNAL_OUT, // Signal
  input wire logic [OSR_NUM_LEDS-1:0] LED_OUT // LEDs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (RESET_IN);
  AST_RD_ANSWER: assert property (CFG_RD_IN |=> CFG_RVALID_OUT)
    else $error("read not answered");
  AST_RD_PULSE: assert property (!CFG_RD_IN |=> !CFG_RVALID_OUT)
    else $error("stray read valid");
  AST_RD_HOLD: assert property (!CFG_RVALID_OUT |-> $stable(CFG_RDATA_OUT))
    else $error("read data moved");
  AST_POWER_THREE: assert property (SOURCES_IN.trip_lockout |=> POWER_OUT[2])
    else $error("lockout missing on power three");
  AST_POWER_TWO: assert property (SOURCES_IN.breaker_failure_trip |=> POWER_OUT[1])
    else $error("breaker failure missing on power two");
  AST_SIGNAL_TWO: assert property (SOURCES_IN.external_fault_warning |=> SIGNAL_OUT[1])
    else $error("fault warning missing on signal two");
  AST_QUIET: assert property (SOURCES_IN == '0 |=> {POWER_OUT, SIGNAL_OUT, LED_OUT} == '0)
    else $error("output held without source");
  AST_ABSENT: assert property ((!IO_EXT_PRESENT_IN [*3] ##0 (CFG_RD_IN && CFG_INDEX_IN inside {[4'h5:4'h7]}))
    |=> CFG_RDATA_OUT == OSR_ABSENT_VALUE)
    else $error("absent word not masked");
endmodule

// ===== verif/osr_contacts.sv
// Purpose: Load model of contacts and indicators.
// Assumes: Contacts follow their coils with no bounce.
// Notes: Gathers all loads into one state word.
module osr_contacts
  import osr_pkg::*;
(
  input wire logic [OSR_NUM_POWER-1:0] POWER_IN, // Power coils
  input wire logic [OSR_NUM_SIGNAL-1:0] SIGNAL_IN, // Signal coils
  input wire logic [OSR_NUM_LEDS-1:0] LED_IN, // LEDs
  output logic [15:0] STATE_OUT // LEDs on top
);
  timeunit 1ns;
  timeprecision 1ps;
  assign STATE_OUT = {LED_IN, SIGNAL_IN, POWER_IN};
endmodule

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the routing matrix.
// Assumes: Inputs move on the falling clock edge.
// Notes: One-hot events expose every single routing.
module tb_top
  import osr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, ext = 1'b0, wr = 1'b0, rd = 1'b0, rv;
  logic [3:0] idx = 4'h0, wi;
  osr_word_t wd = '0, rdata, words [16];
  osr_sources_t src = '0;
  logic [2:0] pw;
  logic [4:0] so;
  logic [7:0] led;
  logic [15:0] seen;
  int failures = 0, checks_done = 0, seed = 20894;
  osr_matrix dut_u (.CLOCK_IN(clk), .RESET_IN(rst), .SOURCES_IN(src), .IO_EXT_PRESENT_IN(ext), .CFG_WR_IN(wr),
    .CFG_RD_IN(rd), .CFG_INDEX_IN(idx), .CFG_WDATA_IN(wd), .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rv),
    .POWER_OUT(pw), .SIGNAL_OUT(so), .LED_OUT(led));
  osr_contacts load_u (.POWER_IN(pw), .SIGNAL_IN(so), .LED_IN(led), .STATE_OUT(seen));
  function automatic logic [15:0] expect_all(osr_sources_t s);
    logic [15:0] e;
    osr_word_t o;
    osr_word_t l;
    for (int k = 0; k < 6; k++)
      o[2*k+:2] = {s.stage_trip[k], s.stage_start[k]};
    o[22:12] = {s.light_output, s.arc_trip, s.auto_reclose_lockout, s.auto_reclose_shot_due,
      s.auto_reclose_failed, s.auto_reclose_definite_trip, s.auto_reclose_close_cmd, s.auto_reclose_open_cmd,
      s.external_trip, s.thermal_trip, s.thermal_alarm};
    l = {s.recorder_triggered, s.breaker_failure_trip, s.light_output, s.arc_trip, s.digital_inputs,
      s.circuit_breaker_closed, s.circuit_breaker_open, s.auto_reclose_lockout, s.auto_reclose_shot_due,
      s.auto_reclose_definite_trip, s.trip_lockout, s.thermal_trip, s.thermal_alarm, s.stage_trip};
    for (int i = 0; i < 16; i++)
      e[i] = |(words[i] & (i < 8 ? o : l));
    e[1] |= s.breaker_failure_trip;
    e[2] |= s.trip_lockout;
    e[4] |= s.external_fault_warning;
    return e;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic access(input logic w, input logic [3:0] i, input osr_word_t d);
    @(negedge clk);
    wr = w;
    rd = !w;
    idx = i;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    if (w)
      words[i] = d;
  endtask
  // Valid stands for only one cycle, so look at the negedge that access ends on
  task automatic read_chk(input logic [3:0] i, input osr_word_t e);
    access(1'b0, i, '0);
    check(rv, 1'b1);
    check(rdata, e);
  endtask
  task automatic test_done();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200us;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      words[i] = i < 3 ? OSR_RST_POWER : i < 5 ? OSR_RST_SIGNAL_START : OSR_RST_ZERO;
      read_chk(4'(i), i inside {[5:7]} ? OSR_ABSENT_VALUE : words[i]);
    end
    ext = 1'b1;
    for (int n = 0; n < 300; n++)
    begin
      wi = n < 16 ? 4'(n) : 4'($random(seed));
      access(1'b1, wi, n < 16 ? '1 : 23'($random(seed)));
      src = '0;
      src[$unsigned($random(seed)) % $bits(osr_sources_t)] = 1'b1;
      @(negedge clk);
      check(seen, expect_all(src));
      read_chk(wi, words[wi]);
      src = '0;
    end
    ext = 1'b0;
    repeat (3) @(negedge clk);
    read_chk(4'h7, OSR_ABSENT_VALUE);
    test_done();
  end
endmodule
bind osr_matrix osr_matrix_sva chk_u (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .SOURCES_IN(SOURCES_IN),
  .IO_EXT_PRESENT_IN(IO_EXT_PRESENT_IN), .CFG_WR_IN(CFG_WR_IN), .CFG_RD_IN(CFG_RD_IN), .CFG_INDEX_IN(CFG_INDEX_IN),
  .CFG_WDATA_IN(CFG_WDATA_IN), .CFG_RDATA_OUT(CFG_RDATA_OUT), .CFG_RVALID_OUT(CFG_RVALID_OUT),
  .POWER_OUT(POWER_OUT), .SIGNAL_OUT(SIGNAL_OUT), .LED_OUT(LED_OUT));
